// ===== iam_regs.svh
// Constants of the I/O assembly image mapper: image sizes, instances, byte and bit positions.
// Assumes a byte-serial image port on one system clock; no software registers.
// Contract
// - Input image is eight bytes, instance 101; inputs in bytes 2-5; bytes 6-7 zero.
// - Input byte 0 bit 7 is one while output supply is below about 18 V.
// - Input byte 1 bit 1 is one while control/input supply is below about 18 V.
// - Output image is twelve bytes, instance 102; bytes 0,1,7,9,10,11 reserved.
// - Valve coils 0..31 come from output bytes 2..5, coil 0 at byte 2 bit 0.
// - First output module channels 0..7 come from output byte 6.
// - Second output module channels 0..7 come from output byte 8.
// - Configuration image is sixteen bytes, instance 103.
`ifndef IAM_REGS_SVH
`define IAM_REGS_SVH
`define IAM_IN_LEN        8'h08
`define IAM_IN_INST       8'h65
`define IAM_OUT_LEN       8'h0C
`define IAM_OUT_INST      8'h66
`define IAM_CFG_LEN       8'h10
`define IAM_CFG_INST      8'h67
`define IAM_IN_PWR_OUT    8'h00
`define IAM_PWR_OUT_BIT   7
`define IAM_IN_PWR_CI     8'h01
`define IAM_PWR_CI_BIT    1
`define IAM_IN_MOD0_LO    8'h02
`define IAM_IN_MOD0_HI    8'h03
`define IAM_IN_MOD1_LO    8'h04
`define IAM_IN_MOD1_HI    8'h05
`define IAM_OUT_COIL0     8'h02
`define IAM_OUT_COIL3     8'h05
`define IAM_OUT_MOD0      8'h06
`define IAM_OUT_MOD1      8'h08
`endif

// ===== iam_pkg.sv
// Types of the I/O assembly image mapper.
// Assumes iam_regs.svh supplies the numeric constants.
package iam_pkg;
    typedef logic [7:0] iam_byte_t;
    typedef enum logic [1:0] {IAM_INST_IN, IAM_INST_OUT, IAM_INST_CFG, IAM_INST_NONE} iam_inst_e;
endpackage

// ===== iam_sync.sv
// Two-flop synchroniser bank for pin-level inputs.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module iam_sync #(
    parameter int W = 34
) (
    input  wire logic         ref_clk, // System clock
    input  wire logic         reset,   // Asynchronous reset, active high
    input  wire logic [W-1:0] din,     // Asynchronous levels
    output var  logic [W-1:0] dout     // Synchronised levels
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule // iam_sync
`default_nettype wire

// ===== iam_mapper.sv
// I/O assembly image mapper: serves the input image byte by byte and unpacks the
// output image into coil and output-module pins. Assumes a byte-serial image port
// from the network stack on ref_clk; field pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "iam_regs.svh"
module iam_mapper (
    input  wire logic              ref_clk,      // 125 MHz system clock
    input  wire logic              reset,        // Asynchronous reset, active high
    input  wire logic [15:0]       in_mod0,      // First input module channels (pins)
    input  wire logic [15:0]       in_mod1,      // Second input module channels (pins)
    input  wire logic              pwr_out_low,  // Output supply below about 18 V (pin)
    input  wire logic              pwr_ci_low,   // Control/input supply below 18 V (pin)
    input  wire logic              rd_req,       // Read one input image byte
    input  wire logic [7:0]        rd_inst,      // Assembly instance of the read
    input  wire logic [7:0]        rd_idx,       // Byte index of the read
    output var  iam_pkg::iam_byte_t rd_data,     // Read byte
    output var  logic              rd_ack,       // Read answered, one-cycle pulse
    output var  logic              rd_err,       // Read refused, one-cycle pulse
    input  wire logic              wr_req,       // Write one output image byte
    input  wire logic [7:0]        wr_inst,      // Assembly instance of the write
    input  wire logic [7:0]        wr_idx,       // Byte index of the write
    input  wire iam_pkg::iam_byte_t wr_data,     // Written byte
    output var  logic              wr_ack,       // Write accepted, one-cycle pulse
    output var  logic              wr_err,       // Write refused, one-cycle pulse
    output var  logic [31:0]       coil,         // Valve coils
    output var  logic [7:0]        out_mod0,     // First output module channels
    output var  logic [7:0]        out_mod1      // Second output module channels
);
    import iam_pkg::*;

    logic [33:0] pins_sync;
    logic [15:0] mod0_s;
    logic [15:0] mod1_s;
    logic        pwr_out_s;
    logic        pwr_ci_s;

    iam_sync #(.W(34)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .din     ({pwr_ci_low, pwr_out_low, in_mod1, in_mod0}),
        .dout    (pins_sync)
    );
    assign mod0_s    = pins_sync[15:0];
    assign mod1_s    = pins_sync[31:16];
    assign pwr_out_s = pins_sync[32];
    assign pwr_ci_s  = pins_sync[33];

    // Classify an access by its assembly instance
    function automatic iam_inst_e inst_of(input logic [7:0] inst);
        iam_inst_e r;
        r = IAM_INST_NONE;
        if (inst == `IAM_IN_INST) r = IAM_INST_IN;
        else if (inst == `IAM_OUT_INST) r = IAM_INST_OUT;
        else if (inst == `IAM_CFG_INST) r = IAM_INST_CFG;
        return r;
    endfunction

    // Input image byte; every bit not listed reads zero
    function automatic iam_byte_t in_byte(input logic [7:0] idx);
        iam_byte_t b;
        b = 8'h00;
        case (idx)
            `IAM_IN_PWR_OUT: b[`IAM_PWR_OUT_BIT] = pwr_out_s;
            `IAM_IN_PWR_CI:  b[`IAM_PWR_CI_BIT]  = pwr_ci_s;
            `IAM_IN_MOD0_LO: b = mod0_s[7:0];
            `IAM_IN_MOD0_HI: b = mod0_s[15:8];
            `IAM_IN_MOD1_LO: b = mod1_s[7:0];
            `IAM_IN_MOD1_HI: b = mod1_s[15:8];
            default:         b = 8'h00;
        endcase
        return b;
    endfunction

    // Configuration image layout is not defined here, so it is accepted and read as zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
            rd_ack  <= 1'b0;
            rd_err  <= 1'b0;
        end else begin
            rd_ack  <= 1'b0;
            rd_err  <= 1'b0;
            rd_data <= 8'h00;
            if (rd_req) begin
                case (inst_of(rd_inst))
                    IAM_INST_IN: begin
                        if (rd_idx < `IAM_IN_LEN) begin
                            rd_data <= in_byte(rd_idx);
                            rd_ack  <= 1'b1;
                        end else begin
                            rd_err <= 1'b1;
                        end
                    end
                    IAM_INST_CFG: begin
                        if (rd_idx < `IAM_CFG_LEN) rd_ack <= 1'b1;
                        else rd_err <= 1'b1;
                    end
                    default: rd_err <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
        end else begin
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
            if (wr_req) begin
                case (inst_of(wr_inst))
                    IAM_INST_OUT: begin
                        if (wr_idx < `IAM_OUT_LEN) wr_ack <= 1'b1;
                        else wr_err <= 1'b1;
                    end
                    IAM_INST_CFG: begin
                        if (wr_idx < `IAM_CFG_LEN) wr_ack <= 1'b1;
                        else wr_err <= 1'b1;
                    end
                    default: wr_err <= 1'b1;
                endcase
            end
        end
    end

    logic wr_out_ok;
    assign wr_out_ok = wr_req && (wr_inst == `IAM_OUT_INST);

    // Lane of a coil byte. The subtraction is cut to two bits on purpose: done at full
    // width it goes negative only for bytes 0 and 1, which the coil range check keeps out of the write.
    logic [1:0] coil_lane;
    assign coil_lane = 2'(wr_idx - `IAM_OUT_COIL0);

    // Reserved bytes fall through untouched; coil bytes are written one lane at a time
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            coil <= 32'h0000_0000;
        end else if (wr_out_ok && wr_idx >= `IAM_OUT_COIL0 && wr_idx <= `IAM_OUT_COIL3) begin
            coil[{coil_lane, 3'b000} +: 8] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_mod0 <= 8'h00;
            out_mod1 <= 8'h00;
        end else if (wr_out_ok) begin
            if (wr_idx == `IAM_OUT_MOD0) out_mod0 <= wr_data;
            if (wr_idx == `IAM_OUT_MOD1) out_mod1 <= wr_data;
        end
    end

    a_in_pad_zero: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_IN_INST && rd_idx >= 8'h06 && rd_idx < 8'h08
        |=> rd_ack && rd_data == 8'h00)
        else $error("input pad byte not zero");
    a_pwr_out_bit: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_IN_INST && rd_idx == 8'h00
        |=> rd_data == {$past(pwr_out_s), 7'h00})
        else $error("byte 0 wrong");
    a_pwr_ci_bit: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_IN_INST && rd_idx == 8'h01
        |=> rd_data == {6'h00, $past(pwr_ci_s), 1'b0})
        else $error("byte 1 wrong");
    a_out_len: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST |=> (wr_ack == ($past(wr_idx) < 8'h0C)) && wr_ack != wr_err)
        else $error("output length check wrong");
    a_coil_byte: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h03 |=> coil[15:8] == $past(wr_data))
        else $error("coil byte not written");
    a_mod0_write: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h06 |=> out_mod0 == $past(wr_data))
        else $error("module 0 not written");
    a_mod1_write: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h08 |=> out_mod1 == $past(wr_data))
        else $error("module 1 not written");
    a_cfg_len: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_CFG_INST |=> rd_ack == ($past(rd_idx) < 8'h10))
        else $error("config length wrong");
    a_resv_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST
        && (wr_idx <= 8'h01 || wr_idx == 8'h07 || wr_idx >= 8'h09)
        |=> $stable(coil) && $stable(out_mod0) && $stable(out_mod1))
        else $error("reserved byte changed outputs");

    c_read_in: cover property (@(posedge ref_clk) disable iff (reset) rd_ack && rd_data != 8'h00);
    c_write_coil: cover property (@(posedge ref_clk) disable iff (reset) wr_ack && coil != 32'h0);
    c_refused: cover property (@(posedge ref_clk) disable iff (reset) wr_err);
    c_cfg_read: cover property (@(posedge ref_clk) disable iff (reset)
        rd_ack && $past(rd_inst) == `IAM_CFG_INST);
    c_supply_low: cover property (@(posedge ref_clk) disable iff (reset) rd_ack && rd_data[7]);

    // Every lane of the coil word, the low half of mod0_s and the high half of mod1_s are checked, since
    // a wrong lane select only shows on the upper bytes.
    a_coil_low: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h02 |=> coil[7:0] == $past(wr_data))
        else $error("coil byte 0 not written");
    a_coil_mid: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h04 |=> coil[23:16] == $past(wr_data))
        else $error("coil byte 2 not written");
    a_coil_top: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req && wr_inst == `IAM_OUT_INST && wr_idx == 8'h05 |=> coil[31:24] == $past(wr_data))
        else $error("coil byte 3 not written");
    a_in_mod0_lo: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_IN_INST && rd_idx == `IAM_IN_MOD0_LO
        |=> rd_data == 8'($past(mod0_s)))
        else $error("input byte 2 wrong");
    a_in_mod1_hi: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req && rd_inst == `IAM_IN_INST && rd_idx == `IAM_IN_MOD1_HI
        |=> rd_data == 8'($past(mod1_s) >> 8))
        else $error("input byte 5 wrong");
    a_rd_answer: assert property (@(posedge ref_clk) disable iff (reset)
        rd_req |=> rd_ack != rd_err)
        else $error("read not answered once");
    a_rd_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !rd_req |=> !rd_ack && !rd_err && rd_data == 8'h00)
        else $error("read answer without request");
    a_wr_answer: assert property (@(posedge ref_clk) disable iff (reset)
        wr_req |=> wr_ack != wr_err)
        else $error("write not answered once");
    a_wr_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !wr_req |=> !wr_ack && !wr_err)
        else $error("write answer without request");
endmodule // iam_mapper
`default_nettype wire

// ===== iam_scanner.sv
// Behavioural network scanner driving the byte-serial image port of the mapper.
// Assumes requests are taken on the rising edge and answered one cycle later.
`timescale 1ns/1ps
`default_nettype none
module iam_scanner (
    input  wire logic       ref_clk, // System clock
    output var  logic       rd_req,  // Read strobe, one cycle
    output var  logic [7:0] rd_inst, // Read instance
    output var  logic [7:0] rd_idx,  // Read byte index
    input  wire logic [7:0] rd_data, // Read byte
    input  wire logic       rd_ack,  // Read answered
    input  wire logic       rd_err,  // Read refused
    output var  logic       wr_req,  // Write strobe, one cycle
    output var  logic [7:0] wr_inst, // Write instance
    output var  logic [7:0] wr_idx,  // Write byte index
    output var  logic [7:0] wr_data, // Written byte
    input  wire logic       wr_ack,  // Write accepted
    input  wire logic       wr_err   // Write refused
);
    initial begin
        {rd_req, rd_inst, rd_idx, wr_req, wr_inst, wr_idx, wr_data} = '0;
    end
    // One transfer; released lines show the inverse so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] inst, input logic [7:0] idx,
                        input logic [7:0] dat, output logic [9:0] ans);
        @(negedge ref_clk);
        if (w) begin
            {wr_req, wr_inst, wr_idx, wr_data} = {1'b1, inst, idx, dat};
        end else begin
            {rd_req, rd_inst, rd_idx} = {1'b1, inst, idx};
        end
        @(negedge ref_clk);
        // The answer stands for one cycle only, so it is taken before the strobe drops
        ans = w ? {wr_ack, wr_err, 8'h00} : {rd_ack, rd_err, rd_data};
        {rd_req, wr_req} = 2'b00;
        {rd_inst, rd_idx, wr_inst, wr_idx, wr_data} = ~{inst, idx, inst, idx, dat};
    endtask
endmodule // iam_scanner
`default_nettype wire

// ===== iam_mapper_bench.sv
// Self-checking bench for the I/O assembly image mapper.
// Assumes iam_scanner drives the image port; the bench drives the field pins.
`timescale 1ns/1ps
`default_nettype none
module iam_mapper_bench;
    import iam_pkg::*;
    logic        ref_clk, reset, pwr_out_low, pwr_ci_low, rd_req, rd_ack, rd_err;
    logic        wr_req, wr_ack, wr_err;
    logic [15:0] in_mod0, in_mod1;
    logic [7:0]  rd_inst, rd_idx, wr_inst, wr_idx, out_mod0, out_mod1;
    iam_byte_t   rd_data, wr_data;
    logic [31:0] coil;
    logic [9:0]  ans;
    int          fail_count = 0;
    int          n_tests = 0;

    iam_mapper dut_u (.ref_clk(ref_clk), .reset(reset), .in_mod0(in_mod0), .in_mod1(in_mod1),
        .pwr_out_low(pwr_out_low), .pwr_ci_low(pwr_ci_low), .rd_req(rd_req),
        .rd_inst(rd_inst), .rd_idx(rd_idx), .rd_data(rd_data), .rd_ack(rd_ack),
        .rd_err(rd_err), .wr_req(wr_req), .wr_inst(wr_inst), .wr_idx(wr_idx),
        .wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .coil(coil),
        .out_mod0(out_mod0), .out_mod1(out_mod1));
    iam_scanner scanner_u (.ref_clk(ref_clk), .rd_req(rd_req), .rd_inst(rd_inst),
        .rd_idx(rd_idx), .rd_data(rd_data), .rd_ack(rd_ack), .rd_err(rd_err),
        .wr_req(wr_req), .wr_inst(wr_inst), .wr_idx(wr_idx), .wr_data(wr_data),
        .wr_ack(wr_ack), .wr_err(wr_err));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Input image with every field at a distinct value, then both supply flags flipped
    task automatic t_inputs(input logic po, input logic pc);
        logic [7:0] exp [8];
        @(negedge ref_clk);
        {in_mod0, in_mod1, pwr_out_low, pwr_ci_low} = {16'hC35A, 16'h81E7, po, pc};
        exp = '{{po, 7'h00}, {6'h00, pc, 1'b0}, 8'h5A, 8'hC3, 8'hE7, 8'h81, 8'h00, 8'h00};
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            scanner_u.xfer(1'b0, 8'h65, i[7:0], 8'h00, ans);
            chk(ans, {2'b10, exp[i]});
        end
    endtask

    // Full output image, reserved bytes carry noise that must not land anywhere
    task automatic t_outputs;
        for (int i = 0; i < 12; i++) begin
            scanner_u.xfer(1'b1, 8'h66, i[7:0], 8'hA0 + i[7:0], ans);
            chk(ans, 10'h200);
        end
        chk(coil, 32'hA5A4A3A2);
        chk(out_mod0, 8'hA6);
        chk(out_mod1, 8'hA8);
        scanner_u.xfer(1'b1, 8'h66, 8'h05, 8'h80, ans);
        chk(coil, 32'h80A4A3A2);
    endtask

    // Out-of-range and wrong-direction accesses, and the configuration image edges
    task automatic t_refuse;
        logic [18:0] tbl [10];
        tbl = '{{1'b0, 8'h65, 8'h08, 2'b01}, {1'b0, 8'h66, 8'h00, 2'b01},
                {1'b1, 8'h65, 8'h00, 2'b01}, {1'b1, 8'h66, 8'h0C, 2'b01},
                {1'b0, 8'h64, 8'h00, 2'b01}, {1'b1, 8'h68, 8'h00, 2'b01},
                {1'b0, 8'h67, 8'h0F, 2'b10}, {1'b0, 8'h67, 8'h10, 2'b01},
                {1'b1, 8'h67, 8'h0F, 2'b10}, {1'b1, 8'h67, 8'h10, 2'b01}};
        for (int i = 0; i < 10; i++) begin
            scanner_u.xfer(tbl[i][18], tbl[i][17:10], tbl[i][9:2], 8'hFF, ans);
            chk(ans, {tbl[i][1:0], 8'h00});
        end
        chk({coil, out_mod0, out_mod1}, 48'h80A4A3A2A6A8);
    endtask

    // Reset in mid-run clears every output
    task automatic t_reset;
        @(negedge ref_clk);
        reset = 1'b1;
        @(negedge ref_clk);
        chk({coil, out_mod0, out_mod1, rd_data, rd_ack, rd_err, wr_ack, wr_err}, 64'h0);
        reset = 1'b0;
        t_inputs(1'b1, 1'b0);
    endtask

    task automatic test_done;
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {reset, in_mod0, in_mod1, pwr_out_low, pwr_ci_low} = {1'b1, 34'h0};
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        t_inputs(1'b1, 1'b0);
        t_inputs(1'b0, 1'b1);
        t_outputs;
        t_refuse;
        t_reset;
        test_done;
    end
endmodule // iam_mapper_bench
`default_nettype wire
